//--- dv/pic_host.sv
/* Management host model that runs whole frames on mdc and mdio.
   Assumes the bench resolves the shared data wire with a pull-up. */
`timescale 1ns/10ps
`default_nettype none
module pic_host (
	// Clock
	input  wire logic clk_sys,
	// Bus
	output logic      mdc,
	output logic      host_oe,
	output logic      host_bit,
	input  wire logic mdio_w
);
	initial begin
		mdc = 1'b0;
		host_oe = 1'b0;
		host_bit = 1'b0;
	end
	task automatic half();
		repeat (4) @(posedge clk_sys);
	endtask : half
	// The clock stands low between frames, so the block sees no stray edges.
	task automatic frame(input logic [4:0] phy, input logic rd, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rv);
		logic [63:0] s;
		s = {32'hFFFFFFFF, 2'b01, rd, !rd, phy, ra, 2'b10, wd};
		for (int i = 63; i >= 0; i--) begin
			half();
			host_oe <= !(rd && i < 18);
			host_bit <= s[i];
			mdc <= 1'b0;
			half();
			if (i < 16) rv[i] = mdio_w;
			mdc <= 1'b1;
		end
		half();
		host_oe <= 1'b0;
		mdc <= 1'b0;
	endtask : frame
endmodule : pic_host
`default_nettype wire

//--- dv/pic_regs_bench.sv
/* Self-checking bench for the register block, driven through the host model.
   Assumes the block answers management address 1. */
`timescale 1ns/10ps
`default_nettype none
module pic_regs_bench;
	logic               clk_sys, rst, mdc, host_oe, host_bit, mdio_w, mdio_o, mdio_oe;
	logic               pair_swap_o, link_pass_o, rx_run, int_pin_o, ind0, ind1;
	pic_pkg::pic_evt_t  evt_i;
	pic_pkg::pic_stat_t stat_i;
	pic_pkg::pic_ctrl_t ctrl_o;
	logic [15:0]        rv;
	int                 errors, comparisons;
	assign mdio_w = mdio_oe ? mdio_o : (host_oe ? host_bit : 1'b1);
	pic_regs i_dut (.clk_sys(clk_sys), .rst(rst), .mdc(mdc), .mdio_i(mdio_w),
		.mdio_o(mdio_o), .mdio_oe(mdio_oe), .evt_i(evt_i), .stat_i(stat_i),
		.ctrl_o(ctrl_o), .pair_swap_o(pair_swap_o), .link_pass_o(link_pass_o),
		.rx_clock_run_o(rx_run), .int_pin_o(int_pin_o), .indicator_0(ind0),
		.indicator_1(ind1));
	pic_host i_host (.clk_sys(clk_sys), .mdc(mdc), .host_oe(host_oe),
		.host_bit(host_bit), .mdio_w(mdio_w));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic rd(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] exp);
		i_host.frame(phy, 1'b1, ra, 16'h0000, rv);
		check({4'h0, rv}, {4'h0, exp});
	endtask : rd
	task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
		i_host.frame(5'h01, 1'b0, ra, wd, rv);
		repeat (4) @(posedge clk_sys);
	endtask : wr
	task automatic stop_test();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : stop_test
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial begin
		#2000000;
		errors++;
		stop_test();
	end
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		evt_i = 8'h00;
		stat_i = 12'hAB0;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		check(ctrl_o, pic_pkg::CTRL_RST);
		rd(5'h01, 5'h1B, 16'h0000);
		rd(5'h01, 5'h1E, 16'h2000);
		rd(5'h01, 5'h1F, 16'h9158);
		check(int_pin_o, 1'b1);
		wr(5'h1F, 16'h6F03);
		rd(5'h01, 5'h1F, 16'h7F5B);
		check(pair_swap_o, 1'b1);
		check(link_pass_o, 1'b1);
		check(int_pin_o, 1'b0);
		check(ctrl_o, 20'h0FF00);
		stat_i.energy_det <= 1'b0;
		repeat (4) @(posedge clk_sys);
		check(rx_run, 1'b0);
		stat_i.energy_det <= 1'b1;
		stat_i.link_ok <= 1'b1;
		stat_i.activity <= 1'b1;
		stat_i.speed100 <= 1'b1;
		repeat (4) @(posedge clk_sys);
		check(rx_run, 1'b1);
		check({ind1, ind0}, 2'h2);
		wr(5'h1E, 16'h4080);
		rd(5'h01, 5'h1E, 16'h6880);
		check({ind1, ind0}, 2'h3);
		wr(5'h1B, 16'h0F00);
		for (int i = 0; i < 8; i++) begin
			evt_i <= 8'h01 << i;
			@(posedge clk_sys);
			evt_i <= 8'h00;
			repeat (3) @(posedge clk_sys);
			check(int_pin_o, i < 4);
			rd(5'h01, 5'h1B, 16'h0F00 | (16'h0001 << i));
			check(int_pin_o, 1'b0);
			rd(5'h01, 5'h1B, 16'h0F00);
		end
		evt_i <= 8'h0A;
		@(posedge clk_sys);
		evt_i <= 8'h00;
		repeat (3) @(posedge clk_sys);
		rd(5'h01, 5'h1B, 16'h0F0A);
		wr(5'h1F, 16'h6E03);
		evt_i <= 8'h80;
		@(posedge clk_sys);
		evt_i <= 8'h00;
		repeat (3) @(posedge clk_sys);
		rd(5'h01, 5'h1B, 16'h0F00);
		rd(5'h02, 5'h1B, 16'hFFFF);
		rd(5'h01, 5'h10, 16'hFFFF);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		check(ctrl_o, pic_pkg::CTRL_RST);
		rd(5'h01, 5'h1F, 16'h9158);
		stop_test();
	end
endmodule : pic_regs_bench
`default_nettype wire

//--- rtl/pic_ind.sv
/*
 * Indicator output selection for the two status lamps.
 * Assumes link, activity and speed are levels on the core clock.
 */
`timescale 1ns/10ps
`default_nettype none

module pic_ind (
	// Clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	// Mode and line state
	input  wire pic_pkg::pic_led_mode_t  led_mode,
	input  wire logic                    link_ok,
	input  wire logic                    activity,
	input  wire logic                    speed100,
	// Lamps
	output logic                         indicator_0,
	output logic                         indicator_1
);

	logic ind0_d;
	logic ind1_d;

	// Reserved modes leave both lamps dark rather than guess a meaning.
	assign ind0_d = (led_mode == pic_pkg::LED_SPD_LNKACT) ? (link_ok & ~activity) :
	                (led_mode == pic_pkg::LED_ACT_LNK)    ? link_ok : 1'b0;
	assign ind1_d = (led_mode == pic_pkg::LED_SPD_LNKACT) ? speed100 :
	                (led_mode == pic_pkg::LED_ACT_LNK)    ? activity : 1'b0;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			indicator_0 <= 1'b0;
			indicator_1 <= 1'b0;
		end else begin
			indicator_0 <= ind0_d;
			indicator_1 <= ind1_d;
		end
	end

endmodule : pic_ind
`default_nettype wire

//--- rtl/pic_pkg.sv
/*
 * Shared definitions for the transceiver interrupt and control register block:
 * register numbers, field positions, reset values, management frame states and
 * the structs that carry events, status and control between the core and block.
 * Assumes it is compiled before every file of the block.
 */
package pic_pkg;

	// ----------------------------------------------------------------
	// Register numbers and management frame constants
	// ----------------------------------------------------------------
	localparam logic [4:0] REG_INT_CS  = 5'h1B;
	localparam logic [4:0] REG_CTL_ONE = 5'h1E;
	localparam logic [4:0] REG_CTL_TWO = 5'h1F;
	localparam logic [1:0] OP_READ     = 2'h2;
	localparam logic [1:0] OP_WRITE    = 2'h1;
	localparam logic [5:0] PRE_BITS    = 6'h20;
	localparam logic [5:0] OP_LAST     = 6'h01;
	localparam logic [5:0] ADDR_LAST   = 6'h09;
	localparam logic [5:0] DATA_LAST   = 6'h0F;
	localparam logic [5:0] CNT_ZERO    = 6'h00;
	localparam logic [5:0] CNT_ONE     = 6'h01;
	localparam logic [15:0] RD_ZERO    = 16'h0000;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int INT_EN_MSB  = 15;
	localparam int INT_EN_LSB  = 8;
	localparam int FLAG_MSB    = 7;
	localparam int C1_LED_MSB  = 15;
	localparam int C1_LED_LSB  = 14;
	localparam int C1_POL      = 13;
	localparam int C1_MDIX     = 11;
	localparam int C1_LOOP     = 7;
	localparam int C2_ALTX     = 15;
	localparam int C2_MDIX_SEL = 14;
	localparam int C2_XOV_DIS  = 13;
	localparam int C2_ENERGY   = 12;
	localparam int C2_FORCE    = 11;
	localparam int C2_PSAVE    = 10;
	localparam int C2_INT_LVL  = 9;
	localparam int C2_JAB_EN   = 8;
	localparam int C2_AN_DONE  = 7;
	localparam int C2_PAUSE    = 6;
	localparam int C2_ISOLATE  = 5;
	localparam int C2_OPM_MSB  = 4;
	localparam int C2_OPM_LSB  = 2;
	localparam int C2_SQE      = 1;
	localparam int C2_SCR_DIS  = 0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		LED_SPD_LNKACT = 2'h0,
		LED_ACT_LNK    = 2'h1,
		LED_RSV_A      = 2'h2,
		LED_RSV_B      = 2'h3
	} pic_led_mode_t;

	typedef enum logic [2:0] {
		MS_PRE   = 3'h0,
		MS_START = 3'h1,
		MS_OP    = 3'h2,
		MS_ADDR  = 3'h3,
		MS_TA    = 3'h4,
		MS_DATA  = 3'h5
	} pic_mdio_st_t;

	// Order matches flag bits 7 down to 0.
	typedef struct packed {
		logic jabber;
		logic rx_err;
		logic page_rx;
		logic pd_fault;
		logic lp_ack;
		logic link_down;
		logic remote_fault;
		logic link_up;
	} pic_evt_t;

	typedef struct packed {
		logic       polarity_rev;
		logic       auto_swap;
		logic       energy_det;
		logic       an_done;
		logic       pause_cap;
		logic       isolate;
		logic [2:0] op_mode;
		logic       link_ok;
		logic       activity;
		logic       speed100;
	} pic_stat_t;

	typedef struct packed {
		pic_led_mode_t led_mode;
		logic          remote_loop;
		logic          alt_xover;
		logic          mdix_sel;
		logic          xover_dis;
		logic          force_link;
		logic          power_save;
		logic          int_level;
		logic          jabber_en;
		logic          sqe_en;
		logic          scram_dis;
		logic [7:0]    int_en;
	} pic_ctrl_t;

	localparam pic_ctrl_t CTRL_RST = '{
		led_mode: LED_SPD_LNKACT, remote_loop: 1'b0, alt_xover: 1'b1,
		mdix_sel: 1'b0, xover_dis: 1'b0, force_link: 1'b0, power_save: 1'b0,
		int_level: 1'b0, jabber_en: 1'b1, sqe_en: 1'b0, scram_dis: 1'b0,
		int_en: 8'h00};
	localparam logic INT_PIN_IDLE = 1'b1;

endpackage : pic_pkg

//--- rtl/pic_regs.sv
/*
 * Interrupt and control register block of a 10/100 transceiver, reached over
 * the serial management pins. Holds the interrupt enables and event flags, two
 * control registers, the interrupt pin, crossover selection and receive clock
 * gating. Assumes core events are one-cycle pulses and status inputs are levels
 * on clk_sys; the management clock and data pins are asynchronous.
 */
`timescale 1ns/10ps
`default_nettype none

module pic_regs #(
	parameter logic [4:0] PHY_ADDR = 5'h01
) (
	// Clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rst,
	// Management pins
	input  wire logic                mdc,
	input  wire logic                mdio_i,
	output logic                     mdio_o,
	output logic                     mdio_oe,
	// Core events and status
	input  wire pic_pkg::pic_evt_t   evt_i,
	input  wire pic_pkg::pic_stat_t  stat_i,
	// Controls to the core
	output var pic_pkg::pic_ctrl_t   ctrl_o,
	output logic                     pair_swap_o,
	output logic                     link_pass_o,
	output logic                     rx_clock_run_o,
	// Pins
	output logic                     int_pin_o,
	output logic                     indicator_0,
	output logic                     indicator_1
);

	// ----------------------------------------------------------------
	// Pin synchronisation and clock edge detection
	// ----------------------------------------------------------------
	logic [1:0] sync_q;
	logic       mdc_prev_q;
	logic       mdc_rise;
	logic       bit_in;

	pic_sync2 #(.W(2)) u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.d_i     ({mdc, mdio_i}),
		.q_o     (sync_q)
	);

	assign mdc_rise = sync_q[1] & ~mdc_prev_q;
	assign bit_in   = sync_q[0];

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	pic_pkg::pic_ctrl_t ctrl_q;
	pic_pkg::pic_ctrl_t ctrl_d;
	pic_pkg::pic_evt_t  flags_q;
	pic_pkg::pic_evt_t  flags_d;
	pic_pkg::pic_evt_t  evt_g;
	logic               int_pin_q;
	logic               int_pin_d;
	logic               irq_act;
	logic               swap_q;
	logic               swap_d;
	logic               rclk_off_q;
	logic               rclk_off_d;
	logic               link_pass_q;

	// ----------------------------------------------------------------
	// Management frame state
	// ----------------------------------------------------------------
	pic_pkg::pic_mdio_st_t st_q;
	pic_pkg::pic_mdio_st_t st_d;
	logic [5:0]            cnt_q;
	logic [5:0]            cnt_d;
	logic [1:0]            op_q;
	logic [1:0]            op_d;
	logic [9:0]            addr_q;
	logic [9:0]            addr_d;
	logic [9:0]            addr_nx;
	logic [15:0]           sh_q;
	logic [15:0]           sh_d;
	logic                  hit_q;
	logic                  hit_d;
	logic                  mo_q;
	logic                  mo_d;
	logic                  moe_q;
	logic                  moe_d;
	logic                  rd_clr;
	logic                  wr_go;
	logic [15:0]           wdata;
	logic [4:0]            wreg;
	logic                  addr_ours;
	logic                  phy_match;
	logic [15:0]           rd_img;
	logic [15:0]           img_int;
	logic [15:0]           img_c1;
	logic [15:0]           img_c2;

	// ----------------------------------------------------------------
	// Read images
	// ----------------------------------------------------------------
	always_comb begin
		img_int = pic_pkg::RD_ZERO;
		img_int[pic_pkg::INT_EN_MSB:pic_pkg::INT_EN_LSB] = ctrl_q.int_en;
		img_int[pic_pkg::FLAG_MSB:0] = flags_q;
		img_c1 = pic_pkg::RD_ZERO;
		img_c1[pic_pkg::C1_LED_MSB:pic_pkg::C1_LED_LSB] = ctrl_q.led_mode;
		img_c1[pic_pkg::C1_POL]  = stat_i.polarity_rev;
		img_c1[pic_pkg::C1_MDIX] = swap_q;
		img_c1[pic_pkg::C1_LOOP] = ctrl_q.remote_loop;
		img_c2 = pic_pkg::RD_ZERO;
		img_c2[pic_pkg::C2_ALTX]     = ctrl_q.alt_xover;
		img_c2[pic_pkg::C2_MDIX_SEL] = ctrl_q.mdix_sel;
		img_c2[pic_pkg::C2_XOV_DIS]  = ctrl_q.xover_dis;
		img_c2[pic_pkg::C2_ENERGY]   = stat_i.energy_det;
		img_c2[pic_pkg::C2_FORCE]    = ctrl_q.force_link;
		img_c2[pic_pkg::C2_PSAVE]    = ctrl_q.power_save;
		img_c2[pic_pkg::C2_INT_LVL]  = ctrl_q.int_level;
		img_c2[pic_pkg::C2_JAB_EN]   = ctrl_q.jabber_en;
		img_c2[pic_pkg::C2_AN_DONE]  = stat_i.an_done;
		img_c2[pic_pkg::C2_PAUSE]    = stat_i.pause_cap;
		img_c2[pic_pkg::C2_ISOLATE]  = stat_i.isolate;
		img_c2[pic_pkg::C2_OPM_MSB:pic_pkg::C2_OPM_LSB] = stat_i.op_mode;
		img_c2[pic_pkg::C2_SQE]      = ctrl_q.sqe_en;
		img_c2[pic_pkg::C2_SCR_DIS]  = ctrl_q.scram_dis;
	end

	assign addr_nx   = {addr_q[8:0], bit_in};
	assign phy_match = (addr_nx[9:5] == PHY_ADDR);
	assign addr_ours = (addr_nx[4:0] == pic_pkg::REG_INT_CS) |
	                   (addr_nx[4:0] == pic_pkg::REG_CTL_ONE) |
	                   (addr_nx[4:0] == pic_pkg::REG_CTL_TWO);
	assign rd_img    = (addr_nx[4:0] == pic_pkg::REG_INT_CS)  ? img_int :
	                   (addr_nx[4:0] == pic_pkg::REG_CTL_ONE) ? img_c1 : img_c2;

	// ----------------------------------------------------------------
	// Management frame sequencer
	// ----------------------------------------------------------------
	// Output changes one sync delay after the rising management clock edge,
	// well inside the 200 ns period, so the host samples it at the next rise.
	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		op_d   = op_q;
		addr_d = addr_q;
		sh_d   = sh_q;
		hit_d  = hit_q;
		mo_d   = mo_q;
		moe_d  = moe_q;
		rd_clr = 1'b0;
		wr_go  = 1'b0;
		if (mdc_rise) begin
			unique case (st_q)
				pic_pkg::MS_PRE: begin
					if (bit_in) begin
						cnt_d = (cnt_q == pic_pkg::PRE_BITS) ? cnt_q : cnt_q + pic_pkg::CNT_ONE;
					end else begin
						st_d  = (cnt_q == pic_pkg::PRE_BITS) ? pic_pkg::MS_START : pic_pkg::MS_PRE;
						cnt_d = pic_pkg::CNT_ZERO;
					end
				end
				pic_pkg::MS_START: begin
					st_d = bit_in ? pic_pkg::MS_OP : pic_pkg::MS_PRE;
				end
				pic_pkg::MS_OP: begin
					op_d  = {op_q[0], bit_in};
					cnt_d = cnt_q + pic_pkg::CNT_ONE;
					if (cnt_q == pic_pkg::OP_LAST) begin
						st_d  = pic_pkg::MS_ADDR;
						cnt_d = pic_pkg::CNT_ZERO;
					end
				end
				pic_pkg::MS_ADDR: begin
					addr_d = addr_nx;
					cnt_d  = cnt_q + pic_pkg::CNT_ONE;
					if (cnt_q == pic_pkg::ADDR_LAST) begin
						cnt_d = pic_pkg::CNT_ZERO;
						st_d  = ((op_q == pic_pkg::OP_READ) | (op_q == pic_pkg::OP_WRITE)) ?
						        pic_pkg::MS_TA : pic_pkg::MS_PRE;
						hit_d = (op_q == pic_pkg::OP_READ) & phy_match & addr_ours;
						if (hit_d) begin
							sh_d   = rd_img;
							rd_clr = (addr_nx[4:0] == pic_pkg::REG_INT_CS);
						end
					end
				end
				pic_pkg::MS_TA: begin
					cnt_d = cnt_q + pic_pkg::CNT_ONE;
					if (cnt_q == pic_pkg::CNT_ZERO) begin
						moe_d = hit_q;
						mo_d  = 1'b0;
					end else begin
						st_d  = pic_pkg::MS_DATA;
						cnt_d = pic_pkg::CNT_ZERO;
						if (hit_q) begin
							mo_d = sh_q[15];
							sh_d = {sh_q[14:0], 1'b0};
						end
					end
				end
				pic_pkg::MS_DATA: begin
					cnt_d = cnt_q + pic_pkg::CNT_ONE;
					if (hit_q) begin
						mo_d = sh_q[15];
						sh_d = {sh_q[14:0], 1'b0};
					end else begin
						sh_d = {sh_q[14:0], bit_in};
					end
					if (cnt_q == pic_pkg::DATA_LAST) begin
						st_d  = pic_pkg::MS_PRE;
						cnt_d = pic_pkg::CNT_ZERO;
						moe_d = 1'b0;
						mo_d  = 1'b0;
						hit_d = 1'b0;
						wr_go = (op_q == pic_pkg::OP_WRITE) & (addr_q[9:5] == PHY_ADDR);
					end
				end
				default: begin
					st_d  = pic_pkg::MS_PRE;
					cnt_d = pic_pkg::CNT_ZERO;
				end
			endcase
		end
	end

	assign wdata = {sh_q[14:0], bit_in};
	assign wreg  = addr_q[4:0];

	// ----------------------------------------------------------------
	// Register writes, flags and derived controls
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_go && wreg == pic_pkg::REG_INT_CS) begin
			ctrl_d.int_en = wdata[pic_pkg::INT_EN_MSB:pic_pkg::INT_EN_LSB];
		end
		if (wr_go && wreg == pic_pkg::REG_CTL_ONE) begin
			ctrl_d.led_mode    = pic_pkg::pic_led_mode_t'(
			                     wdata[pic_pkg::C1_LED_MSB:pic_pkg::C1_LED_LSB]);
			ctrl_d.remote_loop = wdata[pic_pkg::C1_LOOP];
		end
		if (wr_go && wreg == pic_pkg::REG_CTL_TWO) begin
			ctrl_d.alt_xover  = wdata[pic_pkg::C2_ALTX];
			ctrl_d.mdix_sel   = wdata[pic_pkg::C2_MDIX_SEL];
			ctrl_d.xover_dis  = wdata[pic_pkg::C2_XOV_DIS];
			ctrl_d.force_link = wdata[pic_pkg::C2_FORCE];
			ctrl_d.power_save = wdata[pic_pkg::C2_PSAVE];
			ctrl_d.int_level  = wdata[pic_pkg::C2_INT_LVL];
			ctrl_d.jabber_en  = wdata[pic_pkg::C2_JAB_EN];
			ctrl_d.sqe_en     = wdata[pic_pkg::C2_SQE];
			ctrl_d.scram_dis  = wdata[pic_pkg::C2_SCR_DIS];
		end
	end

	// With the counter off no jabber can be seen, so its event is dropped.
	assign evt_g      = pic_pkg::pic_evt_t'({evt_i.jabber & ctrl_q.jabber_en, evt_i[6:0]});
	// A new event in the clearing cycle survives the clear.
	assign flags_d    = pic_pkg::pic_evt_t'((flags_q & ~{8{rd_clr}}) | evt_g);
	assign irq_act    = |(flags_q & ctrl_q.int_en);
	assign int_pin_d  = ctrl_q.int_level ? irq_act : ~irq_act;
	assign swap_d     = ctrl_q.xover_dis ? ctrl_q.mdix_sel : stat_i.auto_swap;
	assign rclk_off_d = ctrl_q.power_save & ~stat_i.energy_det ? 1'b1 :
	                    (~ctrl_q.power_save | (stat_i.energy_det & stat_i.link_ok)) ? 1'b0 :
	                    rclk_off_q;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mdc_prev_q <= 1'b0;
			st_q       <= pic_pkg::MS_PRE;
			cnt_q      <= pic_pkg::CNT_ZERO;
			op_q       <= '0;
			addr_q     <= '0;
			sh_q       <= pic_pkg::RD_ZERO;
			hit_q      <= 1'b0;
			mo_q       <= 1'b0;
			moe_q      <= 1'b0;
		end else begin
			mdc_prev_q <= sync_q[1];
			st_q       <= st_d;
			cnt_q      <= cnt_d;
			op_q       <= op_d;
			addr_q     <= addr_d;
			sh_q       <= sh_d;
			hit_q      <= hit_d;
			mo_q       <= mo_d;
			moe_q      <= moe_d;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_q      <= pic_pkg::CTRL_RST;
			flags_q     <= '0;
			int_pin_q   <= pic_pkg::INT_PIN_IDLE;
			swap_q      <= 1'b0;
			rclk_off_q  <= 1'b0;
			link_pass_q <= 1'b0;
		end else begin
			ctrl_q      <= ctrl_d;
			flags_q     <= flags_d;
			int_pin_q   <= int_pin_d;
			swap_q      <= swap_d;
			rclk_off_q  <= rclk_off_d;
			link_pass_q <= stat_i.link_ok | ctrl_q.force_link;
		end
	end

	assign ctrl_o         = ctrl_q;
	assign pair_swap_o    = swap_q;
	assign link_pass_o    = link_pass_q;
	assign rx_clock_run_o = ~rclk_off_q;
	assign int_pin_o      = int_pin_q;
	assign mdio_o         = mo_q;
	assign mdio_oe        = moe_q;

	// ----------------------------------------------------------------
	// Indicators
	// ----------------------------------------------------------------
	pic_ind u_ind (
		.clk_sys     (clk_sys),
		.rst         (rst),
		.led_mode    (ctrl_q.led_mode),
		.link_ok     (stat_i.link_ok),
		.activity    (stat_i.activity),
		.speed100    (stat_i.speed100),
		.indicator_0 (indicator_0),
		.indicator_1 (indicator_1)
	);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	AST_EN_WRITE: assert property (wr_go && wreg == pic_pkg::REG_INT_CS |=>
		ctrl_q.int_en == $past(wdata[pic_pkg::INT_EN_MSB:pic_pkg::INT_EN_LSB]))
		else $error("interrupt enables not written");
	AST_JAB_SET: assert property (evt_i.jabber && ctrl_q.jabber_en |=> flags_q.jabber)
		else $error("jabber flag not set");
	AST_JAB_GATED: assert property (!flags_q.jabber && !ctrl_q.jabber_en && !rd_clr
		|=> !flags_q.jabber) else $error("jabber flag set while counter off");
	AST_RXERR_SET: assert property (evt_i.rx_err |=> flags_q.rx_err)
		else $error("receive error flag not set");
	AST_PAGE_PD: assert property (evt_i.page_rx || evt_i.pd_fault |=>
		(flags_q.page_rx || flags_q.pd_fault)) else $error("page or fault flag lost");
	AST_ACK_RF: assert property (evt_i.lp_ack ##0 evt_i.remote_fault |=>
		flags_q.lp_ack && flags_q.remote_fault) else $error("ack or remote fault flag lost");
	AST_LINK: assert property ($rose(evt_i.link_up) |=> flags_q.link_up)
		else $error("link up flag not set");
	AST_LED: assert property (ctrl_q.led_mode == pic_pkg::LED_ACT_LNK &&
		$stable(ctrl_q.led_mode) |=> indicator_1 == $past(stat_i.activity))
		else $error("activity lamp wrong");
	AST_SWAP: assert property (ctrl_q.xover_dis |=> pair_swap_o == $past(ctrl_q.mdix_sel))
		else $error("forced pair selection ignored");
	AST_RXC: assert property (ctrl_q.power_save && !stat_i.energy_det |=>
		!rx_clock_run_o) else $error("receive clock not stopped");
	AST_IRQ: assert property (##1 int_pin_o ==
		($past(ctrl_q.int_level) ~^ (|($past(flags_q) & $past(ctrl_q.int_en)))))
		else $error("interrupt pin level wrong");
	AST_CLR: assert property (rd_clr |=> flags_q == $past(evt_g))
		else $error("read clear wrong");
	AST_TURN: assert property ($rose(moe_q) |-> !mo_q ##1 moe_q [*8])
		else $error("read drive dropped early");

	COV_READ_INT: cover property (rd_clr ##[1:1000] !moe_q);
	COV_WRITE_C2: cover property (wr_go && wreg == pic_pkg::REG_CTL_TWO);
	COV_IRQ: cover property (irq_act ##1 rd_clr);

endmodule : pic_regs
`default_nettype wire

//--- rtl/pic_sync2.sv
/*
 * Two flip-flop synchroniser for levels arriving from outside the core clock.
 * Assumes each bit is an independent level; no word coherence is promised.
 */
`timescale 1ns/10ps
`default_nettype none

module pic_sync2 #(
	parameter int W = 2
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst,
	// Data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] meta_q;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			q_o    <= '0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end

endmodule : pic_sync2
`default_nettype wire
